// ==== design/ipmc_defines.vh ====
// constants for the interrupt and power mode controller
`ifndef IPMC_DEFINES_VH
`define IPMC_DEFINES_VH

// register offsets
`define IPMC_OFS_GIE        8'h34
`define IPMC_OFS_STPRC      8'h35
`define IPMC_OFS_HRE1       8'h36
`define IPMC_OFS_HRE2       8'h37
`define IPMC_OFS_HRE3       8'h38
`define IPMC_OFS_IE1        8'h39
`define IPMC_OFS_IE2        8'h3A
`define IPMC_OFS_IE3        8'h3B
`define IPMC_OFS_HST1       8'h3C
`define IPMC_OFS_HST2       8'h3D
`define IPMC_OFS_HST3       8'h3E
`define IPMC_OFS_INIT       8'h40
`define IPMC_OFS_STAT       8'h41

// reset values
`define IPMC_RST_GIE        1'h0
`define IPMC_RST_STPRC      4'h8
`define IPMC_RST_SRC        7'h00
`define IPMC_RST_INIT       4'hF

// event bit positions (also clear-event mask bits)
`define IPMC_EV_TM0         0
`define IPMC_EV_TM2         1
`define IPMC_EV_CMP         2
`define IPMC_EV_TM3         3
`define IPMC_EV_SER         4
`define IPMC_EV_EXTA        5
`define IPMC_EV_P42         6
`define IPMC_NSRC           7

// stop release control fields
`define IPMC_STP_EXTA       0
`define IPMC_STP_PA         1
`define IPMC_STP_PB         2
`define IPMC_STP_P42        3

// vector addresses
`define IPMC_VEC_EXTA       12'h004
`define IPMC_VEC_TM0        12'h008
`define IPMC_VEC_TM2        12'h00C
`define IPMC_VEC_CMP        12'h010
`define IPMC_VEC_TM3        12'h014
`define IPMC_VEC_P42        12'h018
`define IPMC_VEC_SER        12'h01C

// timing: wait after reset or stop release, in machine cycles
`define IPMC_WAIT_MCYC      256
`define IPMC_MCYC_CLKS      4

// synchronised pins
`define IPMC_PIN_W          11

`endif

// ==== design/ipmc_pin_sync.v ====
// two-stage pin synchroniser with falling edge detect
`timescale 1ns/1ps
`include "ipmc_defines.vh"
module ipmc_pin_sync (
    input  wire                   clk,    // system clock
    input  wire                   rst,    // synchronous reset
    input  wire [`IPMC_PIN_W-1:0] pin_in, // raw pins
    output wire [`IPMC_PIN_W-1:0] lvl,    // synchronised level
    output wire [`IPMC_PIN_W-1:0] fall    // one-cycle falling edge pulse
);

    reg [`IPMC_PIN_W-1:0] s1_r;
    reg [`IPMC_PIN_W-1:0] s2_r;
    reg [`IPMC_PIN_W-1:0] s3_r;

    genvar i;
    generate
        for (i = 0; i < `IPMC_PIN_W; i = i + 1) begin : g_pin
            // idle high so reset never fakes an edge
            always @(posedge clk) begin
                if (rst) begin
                    s1_r[i] <= 1'b1;
                    s2_r[i] <= 1'b1;
                    s3_r[i] <= 1'b1;
                end else begin
                    s1_r[i] <= pin_in[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                end
            end
            assign lvl[i]  = s2_r[i];
            assign fall[i] = s3_r[i] & ~s2_r[i];
        end
    endgenerate

endmodule

// ==== design/ipmc_top.v ====
// interrupt priority, hold/stop mode and reset sequencing controller
`timescale 1ns/1ps
`include "ipmc_defines.vh"
module ipmc_top (
    input  wire        ref_clk,                      // system clock 50 MHz
    input  wire        rst,                          // power-on reset, active high
    input  wire        reset_n_pin,                  // external reset pin, active low
    input  wire        wdt_underflow,                // watchdog underflow pulse
    input  wire        external_interrupt_a_pin,     // external interrupt A pin
    input  wire        port_four_bit_two_pin,        // port 4 bit 2 input pin
    input  wire [3:0]  port_a_pin,                   // port A pins
    input  wire [3:0]  port_b_pin,                   // port B pins
    input  wire        timer_zero_evt,               // timer 0 event pulse
    input  wire        timer_two_evt,                // timer 2 event pulse
    input  wire        comparator_evt,               // comparator event pulse
    input  wire        timer_three_evt,              // timer 3 event pulse
    input  wire        serial_evt,                   // serial port event pulse
    input  wire        hold_instr,                   // core executes hold
    input  wire        stop_instr,                   // core executes stop
    input  wire        return_from_interrupt_instr,  // core executes return
    input  wire        clear_event_instr,            // core executes clear-event
    input  wire [7:0]  clear_event_mask,             // clear-event immediate
    input  wire [7:0]  addr,                         // register address
    input  wire [3:0]  wdata,                        // register write data
    input  wire        wr,                           // write strobe
    input  wire        rd,                           // read strobe
    output reg  [3:0]  rdata_r,                      // read data, cycle after rd
    output reg         irq_take_r,                   // interrupt accepted pulse
    output reg  [11:0] irq_vec_r,                    // vector address
    output reg         restart_r,                    // start at 000H pulse
    output reg         core_run_r,                   // core may execute
    output reg         osc_run_r,                    // oscillator running
    output reg         sys_reset_r,                  // system reset to other blocks
    output reg         wdt_flag_r,                   // watchdog flag
    output reg  [3:0]  init_cond_r                   // power-on initial condition
);

    localparam [2:0] ST_RSTW = 3'h0;
    localparam [2:0] ST_RUN  = 3'h1;
    localparam [2:0] ST_HOLD = 3'h2;
    localparam [2:0] ST_STOP = 3'h3;
    localparam [2:0] ST_WAKE = 3'h4;

    localparam integer WAIT_INT  = `IPMC_WAIT_MCYC * `IPMC_MCYC_CLKS;
    localparam [10:0]  WAIT_CLKS = WAIT_INT[10:0];
    localparam [10:0] WAIT_LAST = WAIT_CLKS - 11'h001;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    wire [`IPMC_PIN_W-1:0] pin_lvl;
    wire [`IPMC_PIN_W-1:0] pin_fall;

    ipmc_pin_sync u_sync (
        .clk    (ref_clk),
        .rst    (rst),
        .pin_in ({port_b_pin, port_a_pin, port_four_bit_two_pin,
                  external_interrupt_a_pin, reset_n_pin}),
        .lvl    (pin_lvl),
        .fall   (pin_fall)
    );

    wire pin_rst_low = ~pin_lvl[0];
    wire exta_low    = ~pin_lvl[1];
    wire p42_low     = ~pin_lvl[2];
    wire pa_low      = ~&pin_lvl[6:3];
    wire pb_low      = ~&pin_lvl[10:7];

    ////////////////////////////////////////////////////////////////////////
    // state

    reg  [2:0]              state_r;
    reg  [2:0]              state_nxt;
    reg  [10:0]             cnt_r;
    reg                     gie_r;
    reg                     gie_nxt;
    reg  [`IPMC_NSRC-1:0]   ie_r;
    reg  [`IPMC_NSRC-1:0]   hre_r;
    reg  [`IPMC_NSRC-1:0]   hst_r;
    reg  [`IPMC_NSRC-1:0]   hst_nxt;
    reg  [`IPMC_NSRC-1:0]   pend_r;
    reg  [`IPMC_NSRC-1:0]   pend_nxt;
    reg  [3:0]              stp_r;
    reg  [`IPMC_NSRC-1:0]   sel;
    reg  [11:0]             vec;
    reg  [3:0]              rd_val;

    // system reset: pin held low or watchdog; power-on rst is ORed in separately where used
    wire sys_rst = pin_rst_low | wdt_underflow;

    wire [`IPMC_NSRC-1:0] evt_set = {pin_fall[2], pin_fall[1], serial_evt,
                                     timer_three_evt, comparator_evt,
                                     timer_two_evt, timer_zero_evt};
    wire [`IPMC_NSRC-1:0] clr_evt = clear_event_instr ?
                                    clear_event_mask[`IPMC_NSRC-1:0] :
                                    {`IPMC_NSRC{1'b0}};
    wire [`IPMC_NSRC-1:0] cand    = pend_r & ie_r;
    wire live  = (state_r == ST_RUN) | (state_r == ST_HOLD);
    wire take  = gie_r & live & (|cand);
    wire [`IPMC_NSRC-1:0] hold_rel = pend_r & hre_r;
    wire hold_wake = (state_r == ST_HOLD) & (|hold_rel);
    wire stop_wake = (stp_r[`IPMC_STP_EXTA] & exta_low) |
                     (stp_r[`IPMC_STP_PA] & pa_low) |
                     (stp_r[`IPMC_STP_PB] & pb_low) |
                     (stp_r[`IPMC_STP_P42] & p42_low);
    wire wr_hit = wr & ~sys_rst;

    ////////////////////////////////////////////////////////////////////////
    // priority select

    always @* begin
        sel = {`IPMC_NSRC{1'b0}};
        vec = `IPMC_VEC_SER;
        if (cand[`IPMC_EV_EXTA]) begin
            sel[`IPMC_EV_EXTA] = 1'b1;
            vec = `IPMC_VEC_EXTA;
        end else if (cand[`IPMC_EV_TM0]) begin
            sel[`IPMC_EV_TM0] = 1'b1;
            vec = `IPMC_VEC_TM0;
        end else if (cand[`IPMC_EV_TM2]) begin
            sel[`IPMC_EV_TM2] = 1'b1;
            vec = `IPMC_VEC_TM2;
        end else if (cand[`IPMC_EV_CMP]) begin
            sel[`IPMC_EV_CMP] = 1'b1;
            vec = `IPMC_VEC_CMP;
        end else if (cand[`IPMC_EV_TM3]) begin
            sel[`IPMC_EV_TM3] = 1'b1;
            vec = `IPMC_VEC_TM3;
        end else if (cand[`IPMC_EV_P42]) begin
            sel[`IPMC_EV_P42] = 1'b1;
            vec = `IPMC_VEC_P42;
        end else if (cand[`IPMC_EV_SER]) begin
            sel[`IPMC_EV_SER] = 1'b1;
            vec = `IPMC_VEC_SER;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next values of flags and mode

    always @* begin
        // new events win over any clear in the same cycle
        pend_nxt = (pend_r & ~clr_evt & ~(take ? sel : {`IPMC_NSRC{1'b0}}))
                   | evt_set;
        hst_nxt  = hst_r & ~clr_evt;
        if (hold_wake | (take & (state_r == ST_HOLD))) begin
            hst_nxt = hst_nxt | hold_rel | (take ? sel : {`IPMC_NSRC{1'b0}});
        end
        gie_nxt = gie_r;
        if (return_from_interrupt_instr) begin
            gie_nxt = 1'b1;
        end
        if (wr_hit && addr == `IPMC_OFS_GIE) begin
            gie_nxt = wdata[0];
        end
        if (take) begin
            gie_nxt = 1'b0;
        end
        state_nxt = state_r;
        case (state_r)
            ST_RSTW: begin
                if (cnt_r == WAIT_LAST) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (take) begin
                    state_nxt = ST_RUN;
                end else if (stop_instr) begin
                    state_nxt = ST_STOP;
                end else if (hold_instr && hst_r == {`IPMC_NSRC{1'b0}}) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (take | hold_wake) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_STOP: begin
                if (stop_wake) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (cnt_r == WAIT_LAST) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RSTW;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers and mode sequencing

    always @(posedge ref_clk) begin
        if (rst | sys_rst) begin
            state_r     <= ST_RSTW;
            cnt_r       <= 11'h000;
            gie_r       <= `IPMC_RST_GIE;
            ie_r        <= `IPMC_RST_SRC;
            hre_r       <= `IPMC_RST_SRC;
            hst_r       <= `IPMC_RST_SRC;
            pend_r      <= `IPMC_RST_SRC;
            stp_r       <= `IPMC_RST_STPRC;
            irq_take_r  <= 1'b0;
            irq_vec_r   <= 12'h000;
            restart_r   <= 1'b0;
            core_run_r  <= 1'b0;
            osc_run_r   <= 1'b1;
            sys_reset_r <= 1'b1;
        end else begin
            state_r     <= state_nxt;
            gie_r       <= gie_nxt;
            pend_r      <= pend_nxt;
            hst_r       <= hst_nxt;
            irq_take_r  <= take;
            irq_vec_r   <= take ? vec : irq_vec_r;
            restart_r   <= (state_r == ST_RSTW) & (state_nxt == ST_RUN);
            core_run_r  <= (state_nxt == ST_RUN);
            osc_run_r   <= (state_nxt != ST_STOP);
            sys_reset_r <= 1'b0;
            if (state_nxt != state_r) begin
                cnt_r <= 11'h000;
            end else if (state_r == ST_RSTW || state_r == ST_WAKE) begin
                cnt_r <= cnt_r + 11'h001;
            end
            if (wr_hit) begin
                case (addr)
                    `IPMC_OFS_STPRC: stp_r <= wdata;
                    `IPMC_OFS_HRE1:  hre_r[3:0] <= wdata;
                    `IPMC_OFS_HRE2:  hre_r[4] <= wdata[0];
                    `IPMC_OFS_HRE3:  hre_r[6:5] <= wdata[1:0];
                    `IPMC_OFS_IE1:   ie_r[3:0] <= wdata;
                    `IPMC_OFS_IE2:   ie_r[4] <= wdata[0];
                    `IPMC_OFS_IE3:   ie_r[6:5] <= wdata[1:0];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-on only state: watchdog flag and initial condition

    always @(posedge ref_clk) begin
        if (rst) begin
            wdt_flag_r  <= 1'b0;
            init_cond_r <= `IPMC_RST_INIT;
        end else begin
            if (wdt_underflow) begin
                wdt_flag_r <= 1'b1;
            end
            if (wr && addr == `IPMC_OFS_INIT) begin
                init_cond_r <= wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read

    always @* begin
        case (addr)
            `IPMC_OFS_GIE:   rd_val = {3'h0, gie_r};
            `IPMC_OFS_STPRC: rd_val = stp_r;
            `IPMC_OFS_HRE1:  rd_val = hre_r[3:0];
            `IPMC_OFS_HRE2:  rd_val = {3'h0, hre_r[4]};
            `IPMC_OFS_HRE3:  rd_val = {2'h0, hre_r[6:5]};
            `IPMC_OFS_IE1:   rd_val = ie_r[3:0];
            `IPMC_OFS_IE2:   rd_val = {3'h0, ie_r[4]};
            `IPMC_OFS_IE3:   rd_val = {2'h0, ie_r[6:5]};
            `IPMC_OFS_HST1:  rd_val = hst_r[3:0];
            `IPMC_OFS_HST2:  rd_val = {3'h0, hst_r[4]};
            `IPMC_OFS_HST3:  rd_val = {2'h0, hst_r[6:5]};
            `IPMC_OFS_INIT:  rd_val = init_cond_r;
            `IPMC_OFS_STAT:  rd_val = {state_r == ST_WAKE, state_r == ST_STOP,
                                       state_r == ST_HOLD, wdt_flag_r};
            default:         rd_val = 4'h0;
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= 4'h0;
        end else begin
            rdata_r <= rd ? rd_val : 4'h0;
        end
    end

endmodule

// ==== dv/ipmc_properties.sv ====
// assertion checker for the interrupt and power mode controller
`timescale 1ns/1ps
module ipmc_properties (
    input wire        ref_clk,       // clock
    input wire        rst,           // power-on reset
    input wire        reset_n_pin,   // reset pin
    input wire        wdt_underflow, // watchdog pulse
    input wire        hold_instr,    // hold
    input wire        stop_instr,    // stop
    input wire        irq_take_r,    // accept pulse
    input wire [11:0] irq_vec_r,     // vector
    input wire        restart_r,     // restart pulse
    input wire        core_run_r,    // core runs
    input wire        osc_run_r,     // oscillator runs
    input wire        sys_reset_r,   // system reset
    input wire        wdt_flag_r,    // watchdog flag
    input wire [3:0]  init_cond_r    // initial condition
);
    reg  [10:0] rcnt_r;
    // cycles since the last reset cause, saturating
    wire [10:0] rcnt_nxt = (rst || !reset_n_pin || wdt_underflow) ? 11'h000 :
                           (rcnt_r == 11'h7FF) ? rcnt_r : rcnt_r + 11'h001;
    always @(posedge ref_clk) begin
        rcnt_r <= rcnt_nxt;
    end
    reg         stopped_r;
    reg  [10:0] wk_r;
    // stop seen and not yet back to run; cycles since oscillator restart
    always @(posedge ref_clk) begin
        stopped_r <= (rst || sys_reset_r || core_run_r) ? 1'b0 : (stopped_r || !osc_run_r);
        wk_r      <= (rst || !osc_run_r) ? 11'h000 :
                     (wk_r == 11'h7FF) ? wk_r : wk_r + 11'h001;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    chk_take_single: assert property (irq_take_r |=> !irq_take_r)
        else $error("accept pulse repeated");
    chk_vec_legal: assert property (irq_take_r |-> irq_vec_r[1:0] == 2'h0 &&
        irq_vec_r >= 12'h004 && irq_vec_r <= 12'h01C) else $error("vector out of table");
    chk_take_gated: assert property (irq_take_r |-> $past(osc_run_r) && !$past(sys_reset_r))
        else $error("accept while stopped or reset");
    chk_stop_entry: assert property ($fell(osc_run_r) |->
        $past(stop_instr) || $past(stop_instr, 2)) else $error("oscillator stopped without stop");
    chk_stop_core: assert property (!osc_run_r |-> !core_run_r)
        else $error("core runs in stop");
    chk_hold_entry: assert property ($fell(core_run_r) && !sys_reset_r |->
        $past(hold_instr) || $past(hold_instr, 2) || $past(stop_instr) || $past(stop_instr, 2))
        else $error("core halted without cause");
    chk_restart_wait: assert property (restart_r |->
        rcnt_r >= 11'h3FC && rcnt_r <= 11'h410) else $error("restart wait wrong");
    chk_wake_wait: assert property ($rose(core_run_r) && stopped_r |->
        wk_r >= 11'h3FC && wk_r <= 11'h404) else $error("stop wake wait wrong");
    chk_wake_late: assert property (stopped_r && osc_run_r |-> wk_r <= 11'h404)
        else $error("stop wake too long");
    chk_wdt_reset: assert property (wdt_underflow |=> wdt_flag_r && sys_reset_r)
        else $error("underflow not handled");
    chk_wdt_sticky: assert property (wdt_flag_r |=> wdt_flag_r)
        else $error("watchdog flag lost");
    chk_init_reset: assert property ($fell(rst) |-> init_cond_r == 4'hF)
        else $error("initial condition reset wrong");
endmodule

bind ipmc_top ipmc_properties i_chk (.ref_clk(ref_clk), .rst(rst), .reset_n_pin(reset_n_pin),
    .wdt_underflow(wdt_underflow), .hold_instr(hold_instr), .stop_instr(stop_instr),
    .irq_take_r(irq_take_r), .irq_vec_r(irq_vec_r), .restart_r(restart_r),
    .core_run_r(core_run_r), .osc_run_r(osc_run_r), .sys_reset_r(sys_reset_r),
    .wdt_flag_r(wdt_flag_r), .init_cond_r(init_cond_r));

// ==== dv/ipmc_pin_model.sv ====
// pin-side model: interrupt pins, wake ports and reset pin
`timescale 1ns/1ps
module ipmc_pin_model (
    input  wire       ref_clk, // clock
    input  wire       fall_a,  // pulse ext A low
    input  wire       fall_p,  // pulse port4.2 low
    input  wire       wake_pa, // hold port A bit 0 low
    input  wire       rst_req, // pulse reset pin low
    output wire       ext_a,   // ext A pin
    output wire       p42,     // port4.2 pin
    output wire [3:0] pa,      // port A pins
    output wire [3:0] pb,      // port B pins
    output wire       rst_n    // reset pin
);
    logic [3:0] a_r = 4'h0;
    logic [3:0] p_r = 4'h0;
    logic [3:0] r_r = 4'h0;
    always @(posedge ref_clk) begin
        a_r <= fall_a ? 4'h4 : a_r - {3'h0, |a_r};
        p_r <= fall_p ? 4'h4 : p_r - {3'h0, |p_r};
        r_r <= rst_req ? 4'h8 : r_r - {3'h0, |r_r};
    end
    // released pins return high on their pull-ups
    assign ext_a = ~|a_r;
    assign p42   = ~|p_r;
    assign pa    = {3'h7, ~wake_pa};
    assign pb    = 4'hF;
    assign rst_n = ~|r_r;
endmodule

// ==== dv/ipmc_top_tb_top.sv ====
// self-checking bench for the interrupt and power mode controller
`timescale 1ns/1ps
module ipmc_top_tb_top;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic        wake_pa = 1'b0;
    logic [12:0] pv      = 13'h0000;
    logic [7:0]  cmask   = 8'h00;
    logic [7:0]  addr    = 8'h00;
    logic [3:0]  wdata   = 4'h0;
    logic [7:0]  lf      = 8'h5B;
    wire         ext_a, p42, rst_n, take, restart, run, osc, sres, wflag;
    wire  [3:0]  pa, pb, rdata, initc;
    wire  [11:0] vec;
    int          n_fail = 0;
    int          n_checks = 0;
    int          pend;
    int          b;
    int          pri [7] = '{5, 0, 1, 2, 3, 6, 4};
    logic [11:0] vt [7]  = '{12'h008, 12'h00C, 12'h010, 12'h014, 12'h01C, 12'h004, 12'h018};
    logic [7:0]  ra [13] = '{8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B,
                             8'h3C, 8'h3D, 8'h3E, 8'h40, 8'h50};
    ipmc_top i_dut (.ref_clk(ref_clk), .rst(rst), .reset_n_pin(rst_n), .wdt_underflow(pv[9]),
        .external_interrupt_a_pin(ext_a), .port_four_bit_two_pin(p42), .port_a_pin(pa),
        .port_b_pin(pb), .timer_zero_evt(pv[0]), .timer_two_evt(pv[1]),
        .comparator_evt(pv[2]), .timer_three_evt(pv[3]), .serial_evt(pv[4]),
        .hold_instr(pv[5]), .stop_instr(pv[6]), .return_from_interrupt_instr(pv[7]),
        .clear_event_instr(pv[8]), .clear_event_mask(cmask), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata_r(rdata), .irq_take_r(take), .irq_vec_r(vec),
        .restart_r(restart), .core_run_r(run), .osc_run_r(osc), .sys_reset_r(sres),
        .wdt_flag_r(wflag), .init_cond_r(initc));
    ipmc_pin_model i_pins (.ref_clk(ref_clk), .fall_a(pv[10]), .fall_p(pv[11]),
        .wake_pa(wake_pa), .rst_req(pv[12]), .ext_a(ext_a), .p42(p42), .pa(pa), .pb(pb),
        .rst_n(rst_n));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic int nxt();
        foreach (pri[i]) begin
            if (pend[pri[i]]) return pri[i];
        end
        return 0;
    endfunction
    task automatic results();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic hang(input bit ok);
        if (!ok) begin
            chk("wait", 12'h001, 12'h000);
            results();
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [3:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [3:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask
    task automatic pls(input logic [12:0] m, input logic [7:0] cm);
        @(posedge ref_clk);
        pv <= m;
        cmask <= cm;
        @(posedge ref_clk);
        pv <= 13'h0000;
    endtask
    task automatic wt(input logic [11:0] e, input bit want);
        bit seen;
        seen = 1'b0;
        repeat (40) begin
            @(posedge ref_clk);
            #1;
            if (take === 1'b1) begin
                seen = 1'b1;
                break;
            end
        end
        if (want) hang(seen);
        chk("take", {11'h000, want}, {11'h000, seen});
        if (want) chk("vector", e, vec);
    endtask
    task automatic wrun();
        int i;
        for (i = 0; i < 1200 && run !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        hang(run === 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (ra[i]) rd_reg(ra[i], i == 1 ? 4'h8 : (i == 11 ? 4'hF : 4'h0));
        wrun();
        chk("restart", 12'h001, {11'h000, restart});
        for (int i = 0; i < 3; i++) begin
            lf = lfsr(lf);
            wr_reg(8'h36 + i[7:0], lf[3:0]);
            rd_reg(8'h36 + i[7:0], lf[3:0] & (i == 0 ? 4'hF : (i == 1 ? 4'h1 : 4'h3)));
            wr_reg(8'h36 + i[7:0], 4'h0);
        end
        wr_reg(8'h3C, 4'hF);
        rd_reg(8'h3C, 4'h0);
        wr_reg(8'h50, 4'hF);
        rd_reg(8'h50, 4'h0);
        $display("test registers done");
        wr_reg(8'h39, 4'hF);
        wr_reg(8'h3A, 4'h1);
        wr_reg(8'h3B, 4'h3);
        pls(13'h0C1F, 8'h00);
        pend = 'h7F;
        tick(8);
        for (int k = 0; k < 7; k++) begin
            if (k[0]) pls(13'h0080, 8'h00);
            else wr_reg(8'h34, 4'h1);
            b = nxt();
            wt(vt[b], 1'b1);
            pend &= ~(1 << b);
            rd_reg(8'h34, 4'h0);
        end
        $display("test priority done");
        pls(13'h0008, 8'h00);
        wr_reg(8'h3A, 4'h0);
        pls(13'h0010, 8'h00);
        pls(13'h0100, 8'h08);
        wr_reg(8'h34, 4'h1);
        wt(12'h000, 1'b0);
        wr_reg(8'h3A, 4'h1);
        wt(12'h01C, 1'b1);
        $display("test clear done");
        wr_reg(8'h36, 4'h2);
        pls(13'h0020, 8'h00);
        tick(2);
        chk("run", 12'h000, {11'h000, run});
        chk("osc", 12'h001, {11'h000, osc});
        pls(13'h0002, 8'h00);
        wrun();
        rd_reg(8'h3C, 4'h2);
        pls(13'h0020, 8'h00);
        tick(3);
        chk("run", 12'h001, {11'h000, run});
        pls(13'h0100, 8'h02);
        rd_reg(8'h3C, 4'h0);
        wr_reg(8'h36, 4'h0);
        wr_reg(8'h34, 4'h1);
        wt(12'h000, 1'b0);
        pls(13'h0020, 8'h00);
        tick(2);
        pls(13'h0001, 8'h00);
        wt(12'h008, 1'b1);
        wrun();
        pls(13'h0100, 8'h01);
        rd_reg(8'h3C, 4'h0);
        $display("test hold done");
        wr_reg(8'h35, 4'h2);
        pls(13'h0040, 8'h00);
        tick(3);
        chk("osc", 12'h000, {11'h000, osc});
        wake_pa <= 1'b1;
        wrun();
        chk("restart", 12'h000, {11'h000, restart});
        wake_pa <= 1'b0;
        $display("test stop done");
        wr_reg(8'h40, 4'h5);
        pls(13'h0200, 8'h00);
        #1;
        chk("sysreset", 12'h001, {11'h000, sres});
        wrun();
        chk("wdtflag", 12'h001, {11'h000, wflag});
        rd_reg(8'h40, 4'h5);
        rd_reg(8'h39, 4'h0);
        wr_reg(8'h39, 4'hF);
        pls(13'h1000, 8'h00);
        tick(12);
        wrun();
        chk("restart", 12'h001, {11'h000, restart});
        rd_reg(8'h39, 4'h0);
        chk("wdtflag", 12'h001, {11'h000, wflag});
        @(posedge ref_clk);
        rst <= 1'b1;
        tick(4);
        rst <= 1'b0;
        tick(1);
        chk("wdtflag", 12'h000, {11'h000, wflag});
        chk("initcond", 12'h00F, {8'h00, initc});
        $display("test resets done");
        results();
    end
endmodule
